// ### shared/cdc_pkg.sv
// Package with register map, field positions, reset values and codes of the converter block.
package cdc_pkg;

  // Device register offsets, one byte each, high byte first.
  localparam logic [4:0]  ADDR_STATUS     = 5'h00;
  localparam logic [4:0]  ADDR_RES1_HI    = 5'h01;
  localparam logic [4:0]  ADDR_RES1_LO    = 5'h02;
  localparam logic [4:0]  ADDR_RES2_HI    = 5'h03;
  localparam logic [4:0]  ADDR_RES2_LO    = 5'h04;
  localparam logic [4:0]  ADDR_ZERO1_HI   = 5'h05;
  localparam logic [4:0]  ADDR_ZERO1_LO   = 5'h06;
  localparam logic [4:0]  ADDR_ZERO2_HI   = 5'h07;
  localparam logic [4:0]  ADDR_ZERO2_LO   = 5'h08;
  localparam logic [4:0]  ADDR_SCALE1_HI  = 5'h09;
  localparam logic [4:0]  ADDR_SCALE1_LO  = 5'h0a;
  localparam logic [4:0]  ADDR_SETUP1     = 5'h0b;
  localparam logic [4:0]  ADDR_SCALE2_HI  = 5'h0c;
  localparam logic [4:0]  ADDR_SCALE2_LO  = 5'h0d;
  localparam logic [4:0]  ADDR_SETUP2     = 5'h0e;

  // Status and setup field positions.
  localparam int          STAT_SLEEP_BIT  = 7;
  localparam int          STAT_LASTCH_BIT = 2;
  localparam int          STAT_PEND2_BIT  = 1;
  localparam int          STAT_PEND1_BIT  = 0;
  localparam int          SETUP_SPAN_HI   = 7;
  localparam int          SETUP_SPAN_LO   = 6;
  localparam int          SETUP_DIFF_BIT  = 5;

  // Reset values and setup write mask.
  localparam logic [15:0] RESULT_RST      = 16'h0000;
  localparam logic [15:0] ZERO_COEFF_RST  = 16'h8000;
  localparam logic [7:0]  SETUP_RST       = 8'h00;
  localparam logic [7:0]  SETUP_WR_MASK   = 8'he0;

  // Result arithmetic constants.
  localparam logic [15:0] DIFF_BASE       = 16'h8000;
  localparam logic [15:0] SE_BASE         = 16'h3000;
  localparam logic [15:0] RESULT_MAX      = 16'hfff0;
  localparam logic [15:0] RESULT_MASK     = 16'hfff0;

  // Host controller software registers and fields.
  localparam logic [1:0]  HOST_CMD        = 2'h0;
  localparam logic [1:0]  HOST_DATA       = 2'h1;
  localparam logic [1:0]  HOST_STAT       = 2'h2;
  localparam int          CMD_READ_BIT    = 8;
  localparam int          CMD_TWO_BIT     = 9;

endpackage

// ### shared/cdc_link.sv
// Interface joining the host controller and the converter register logic.
`timescale 1ns/10ps
`default_nettype none
interface cdc_link;
  logic       xfer_start;
  logic [4:0] ptr;
  logic       wr_en;
  logic [7:0] wr_byte;
  logic       rd_en;
  logic [7:0] rd_byte;
  logic       stop;

  modport device (input xfer_start, input ptr, input wr_en, input wr_byte, input rd_en,
                  input stop, output rd_byte);
  modport host (output xfer_start, output ptr, output wr_en, output wr_byte, output rd_en,
                output stop, input rd_byte);
endinterface
`default_nettype wire

// ### design/cdc_device.sv
// Result, calibration and setup register logic of the two-channel converter.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// [RQ1] Status bit 7 shows supply low or sleep.
// [RQ2] Status bits 6 to 3 read zero.
// [RQ3] Status bit 2 names last converted channel.
// [RQ4] Bit 1 low: unread channel 2 result.
// [RQ5] Bit 0 low: unread channel 1 result.
// [RQ6] Twelve-bit result, low four bits zero.
// [RQ7] Results clamp to 0x0000 through 0xfff0.
// [RQ8] Differential: scaled offset-corrected code plus midscale.
// [RQ9] Single-ended: scaled offset-corrected code, no midscale.
// [RQ10] Result dropped while its read is open.
// [RQ11] A result read stays open until stop.
// [RQ12] Host reads both result bytes in one transfer.
// [RQ13] Offset coefficients read/write, reset 0x8000.
// [RQ14] Offset calibration stores zero-scale coefficient.
// [RQ15] Host-written offset is used in results.
// [RQ16] Host recalibrates or rewrites offset on mode change.
// [RQ17] Each channel has own coefficients.
// [RQ18] Gain factor is (65536 + gain) / 65536.
// [RQ19] Setup bit 5 selects differential input.
// [RQ20] Setup bits 7 and 6 select span.
// [RQ21] Host writes zeros to setup bits 4..0.
// [RQ22] Pointer advances each byte until stop.
// [RQ23] Reading a result sets its ready flag.
module cdc_device #(
  parameter logic [15:0] SCALE_CH1_INIT = 16'h0000,
  parameter logic [15:0] SCALE_CH2_INIT = 16'h0000
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        ce,
  cdc_link.device          link,
  input  wire logic        conv_done,
  input  wire logic        conv_chan,
  input  wire logic        conv_offset_cal,
  input  wire logic [15:0] conv_raw,
  input  wire logic        supply_low,
  input  wire logic        power_down_mode,
  output logic      [1:0]  span_sel_ch1,
  output logic             diff_input_select_ch1,
  output logic      [1:0]  span_sel_ch2,
  output logic             diff_input_select_ch2
);

  logic [15:0] result_q [2];
  logic [15:0] zero_q   [2];
  logic [15:0] scale_q  [2];
  logic [7:0]  setup_q  [2];
  logic        pend_n_q [2];
  logic        rd_open_q[2];
  logic        last_channel_flag_q;
  logic        supply_low_or_sleep_flag_q;
  logic [4:0]  ptr_q;
  logic [7:0]  rd_byte_q;
  logic [7:0]  status;
  logic [7:0]  rd_mux;
  logic [1:0]  rd_hit;
  logic [15:0] calc_result;
  logic [15:0] cal_coeff;
  logic        store_result;

  assign link.rd_byte          = rd_byte_q;
  assign span_sel_ch1          = setup_q[0][cdc_pkg::SETUP_SPAN_HI:cdc_pkg::SETUP_SPAN_LO];
  assign span_sel_ch2          = setup_q[1][cdc_pkg::SETUP_SPAN_HI:cdc_pkg::SETUP_SPAN_LO];
  assign diff_input_select_ch1 = setup_q[0][cdc_pkg::SETUP_DIFF_BIT];
  assign diff_input_select_ch2 = setup_q[1][cdc_pkg::SETUP_DIFF_BIT];

  // Address of the current byte: pointer is reloaded at transfer start.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ptr_q <= 5'h00;
    end else if (ce) begin
      if (link.xfer_start) begin
        ptr_q <= link.ptr;
      end else if (link.wr_en || link.rd_en) begin
        ptr_q <= ptr_q + 5'h01; // RQ22
      end
    end
  end

  // Result arithmetic for the channel that just converted.
  always_comb begin
    logic               diff;
    logic [15:0]        base;
    logic signed [18:0] corrected;
    logic signed [37:0] prod;
    logic signed [21:0] scaled;
    diff      = setup_q[conv_chan][cdc_pkg::SETUP_DIFF_BIT]; // RQ19
    base      = diff ? cdc_pkg::DIFF_BASE : cdc_pkg::SE_BASE;
    corrected = $signed({3'b000, conv_raw}) - $signed({3'b000, zero_q[conv_chan]})
                + $signed({3'b000, base}); // RQ15
    prod      = corrected * $signed({2'b01, scale_q[conv_chan]}); // RQ18
    scaled    = prod[37:16];
    if (diff) begin
      scaled = scaled + $signed({6'h00, cdc_pkg::DIFF_BASE}); // RQ8
    end
    if (scaled < 0) begin
      calc_result = 16'h0000; // RQ7
    end else if (scaled > $signed({6'h00, cdc_pkg::RESULT_MAX})) begin
      calc_result = cdc_pkg::RESULT_MAX; // RQ7
    end else begin
      calc_result = scaled[15:0] & cdc_pkg::RESULT_MASK; // RQ6 RQ9
    end
    cal_coeff = conv_raw + base; // RQ14
  end

  // A result read of the addressed channel blocks the update in the same cycle too.
  always_comb begin
    rd_hit[0] = link.rd_en && (ptr_q == cdc_pkg::ADDR_RES1_HI || ptr_q == cdc_pkg::ADDR_RES1_LO);
    rd_hit[1] = link.rd_en && (ptr_q == cdc_pkg::ADDR_RES2_HI || ptr_q == cdc_pkg::ADDR_RES2_LO);
  end

  assign store_result = conv_done && !conv_offset_cal && !rd_open_q[conv_chan]
                        && !rd_hit[conv_chan]; // RQ10

  // Read-open tracking: set by a result byte read, cleared by stop.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_open_q[0] <= 1'b0;
      rd_open_q[1] <= 1'b0;
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (rd_hit[c]) begin
          rd_open_q[c] <= 1'b1;
        end else if (link.stop) begin
          rd_open_q[c] <= 1'b0; // RQ11
        end
      end
    end
  end

  // Results and ready flags; a read of the same channel blocks a fresh result, so the read sets the flag.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int c = 0; c < 2; c++) begin
        result_q[c] <= cdc_pkg::RESULT_RST;
        pend_n_q[c] <= 1'b1;
      end
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (store_result && (conv_chan == c[0])) begin
          result_q[c] <= calc_result; // RQ10 RQ17
          pend_n_q[c] <= 1'b0; // RQ4 RQ5
        end else if (rd_hit[c]) begin
          pend_n_q[c] <= 1'b1; // RQ23
        end
      end
    end
  end

  // Status source flags.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      last_channel_flag_q        <= 1'b0;
      supply_low_or_sleep_flag_q <= 1'b0;
    end else if (ce) begin
      supply_low_or_sleep_flag_q <= supply_low || power_down_mode; // RQ1
      if (conv_done && !conv_offset_cal) begin
        last_channel_flag_q <= conv_chan; // RQ3
      end
    end
  end

  // Offset coefficients: calibration result takes priority over a host byte write.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      zero_q[0] <= cdc_pkg::ZERO_COEFF_RST; // RQ13
      zero_q[1] <= cdc_pkg::ZERO_COEFF_RST; // RQ13
    end else if (ce) begin
      if (conv_done && conv_offset_cal) begin
        zero_q[conv_chan] <= cal_coeff; // RQ14 RQ17
      end else if (link.wr_en) begin
        case (ptr_q)
          cdc_pkg::ADDR_ZERO1_HI: zero_q[0][15:8] <= link.wr_byte; // RQ15
          cdc_pkg::ADDR_ZERO1_LO: zero_q[0][7:0]  <= link.wr_byte; // RQ15
          cdc_pkg::ADDR_ZERO2_HI: zero_q[1][15:8] <= link.wr_byte; // RQ15
          cdc_pkg::ADDR_ZERO2_LO: zero_q[1][7:0]  <= link.wr_byte; // RQ15
          default: begin
          end
        endcase
      end
    end
  end

  // Gain coefficients and setup registers; reserved setup bits are stored as zero.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scale_q[0] <= SCALE_CH1_INIT;
      scale_q[1] <= SCALE_CH2_INIT;
      setup_q[0] <= cdc_pkg::SETUP_RST;
      setup_q[1] <= cdc_pkg::SETUP_RST;
    end else if (ce && link.wr_en) begin
      case (ptr_q)
        cdc_pkg::ADDR_SCALE1_HI: scale_q[0][15:8] <= link.wr_byte; // RQ17
        cdc_pkg::ADDR_SCALE1_LO: scale_q[0][7:0]  <= link.wr_byte; // RQ17
        cdc_pkg::ADDR_SCALE2_HI: scale_q[1][15:8] <= link.wr_byte; // RQ17
        cdc_pkg::ADDR_SCALE2_LO: scale_q[1][7:0]  <= link.wr_byte; // RQ17
        cdc_pkg::ADDR_SETUP1:    setup_q[0] <= link.wr_byte & cdc_pkg::SETUP_WR_MASK; // RQ20
        cdc_pkg::ADDR_SETUP2:    setup_q[1] <= link.wr_byte & cdc_pkg::SETUP_WR_MASK; // RQ20
        default: begin
        end
      endcase
    end
  end

  // Read data path.
  always_comb begin
    status = 8'h00; // RQ2
    status[cdc_pkg::STAT_SLEEP_BIT]  = supply_low_or_sleep_flag_q; // RQ1
    status[cdc_pkg::STAT_LASTCH_BIT] = last_channel_flag_q; // RQ3
    status[cdc_pkg::STAT_PEND2_BIT]  = pend_n_q[1]; // RQ4
    status[cdc_pkg::STAT_PEND1_BIT]  = pend_n_q[0]; // RQ5
    case (ptr_q)
      cdc_pkg::ADDR_STATUS:    rd_mux = status;
      cdc_pkg::ADDR_RES1_HI:   rd_mux = result_q[0][15:8];
      cdc_pkg::ADDR_RES1_LO:   rd_mux = result_q[0][7:0];
      cdc_pkg::ADDR_RES2_HI:   rd_mux = result_q[1][15:8];
      cdc_pkg::ADDR_RES2_LO:   rd_mux = result_q[1][7:0];
      cdc_pkg::ADDR_ZERO1_HI:  rd_mux = zero_q[0][15:8];
      cdc_pkg::ADDR_ZERO1_LO:  rd_mux = zero_q[0][7:0];
      cdc_pkg::ADDR_ZERO2_HI:  rd_mux = zero_q[1][15:8];
      cdc_pkg::ADDR_ZERO2_LO:  rd_mux = zero_q[1][7:0];
      cdc_pkg::ADDR_SCALE1_HI: rd_mux = scale_q[0][15:8];
      cdc_pkg::ADDR_SCALE1_LO: rd_mux = scale_q[0][7:0];
      cdc_pkg::ADDR_SETUP1:    rd_mux = setup_q[0];
      cdc_pkg::ADDR_SCALE2_HI: rd_mux = scale_q[1][15:8];
      cdc_pkg::ADDR_SCALE2_LO: rd_mux = scale_q[1][7:0];
      cdc_pkg::ADDR_SETUP2:    rd_mux = setup_q[1];
      default:                 rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_byte_q <= 8'h00;
    end else if (ce && link.rd_en) begin
      rd_byte_q <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ### design/cdc_host.sv
// Host controller that runs register transfers to the converter on software command.
`timescale 1ns/10ps
`default_nettype none
module cdc_host (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [1:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  cdc_link.host            link
);

  typedef enum logic [2:0] {H_IDLE, H_BYTE, H_WAIT, H_CAP, H_END} host_state_t;

  host_state_t state_q;
  logic [9:0]  cmd_q;
  logic [15:0] data_q;
  logic        second_q;
  logic        xfer_start_q;
  logic [4:0]  ptr_q;
  logic        wr_en_q;
  logic [7:0]  wr_byte_q;
  logic        rd_en_q;
  logic        stop_q;
  logic [15:0] rdata_q;
  logic        cmd_take;

  assign link.xfer_start = xfer_start_q;
  assign link.ptr        = ptr_q;
  assign link.wr_en      = wr_en_q;
  assign link.wr_byte    = wr_byte_q;
  assign link.rd_en      = rd_en_q;
  assign link.stop       = stop_q;
  assign rdata           = rdata_q;
  assign cmd_take        = wr && (addr == cdc_pkg::HOST_CMD) && (state_q == H_IDLE);

  // One transfer: start with pointer, one or two bytes, then stop.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q      <= H_IDLE;
      cmd_q        <= 10'h000;
      second_q     <= 1'b0;
      xfer_start_q <= 1'b0;
      ptr_q        <= 5'h00;
      wr_en_q      <= 1'b0;
      wr_byte_q    <= 8'h00;
      rd_en_q      <= 1'b0;
      stop_q       <= 1'b0;
    end else if (ce) begin
      xfer_start_q <= 1'b0;
      wr_en_q      <= 1'b0;
      rd_en_q      <= 1'b0;
      stop_q       <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (cmd_take) begin
            cmd_q        <= wdata[9:0];
            ptr_q        <= wdata[4:0];
            second_q     <= 1'b0;
            xfer_start_q <= 1'b1;
            state_q      <= H_BYTE;
          end
        end
        H_BYTE: begin
          if (cmd_q[cdc_pkg::CMD_READ_BIT]) begin
            rd_en_q <= 1'b1;
            state_q <= H_WAIT;
          end else begin
            wr_en_q   <= 1'b1;
            wr_byte_q <= (cmd_q[cdc_pkg::CMD_TWO_BIT] && !second_q) ? data_q[15:8] : data_q[7:0];
            second_q  <= 1'b1;
            if (!cmd_q[cdc_pkg::CMD_TWO_BIT] || second_q) begin
              state_q <= H_END;
            end
          end
        end
        H_WAIT: begin
          state_q <= H_CAP;
        end
        H_CAP: begin
          second_q <= 1'b1;
          if (cmd_q[cdc_pkg::CMD_TWO_BIT] && !second_q) begin
            rd_en_q <= 1'b1; // RQ12
            state_q <= H_WAIT;
          end else begin
            stop_q  <= 1'b1;
            state_q <= H_IDLE;
          end
        end
        H_END: begin
          stop_q  <= 1'b1;
          state_q <= H_IDLE;
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // Data register: software loads bytes to write; read bytes shift in from the low end.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_q <= 16'h0000;
    end else if (ce) begin
      if (state_q == H_CAP) begin
        data_q <= {data_q[7:0], link.rd_byte};
      end else if (wr && (addr == cdc_pkg::HOST_DATA) && (state_q == H_IDLE)) begin
        data_q <= wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= 16'h0000;
    end else if (ce) begin
      if (rd) begin
        case (addr)
          cdc_pkg::HOST_CMD:  rdata_q <= {6'h00, cmd_q};
          cdc_pkg::HOST_DATA: rdata_q <= data_q;
          cdc_pkg::HOST_STAT: rdata_q <= {15'h0000, state_q != H_IDLE};
          default:            rdata_q <= 16'h0000;
        endcase
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

endmodule
`default_nettype wire

// ### dv/cdc_link_checker.sv
// Concurrent checks on the link between the host controller and the converter registers.
`timescale 1ns/10ps
`default_nettype none
module cdc_link_checker (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       xfer_start,
  input wire logic [4:0] ptr,
  input wire logic       wr_en,
  input wire logic [7:0] wr_byte,
  input wire logic       rd_en,
  input wire logic [7:0] rd_byte,
  input wire logic       stop
);
  logic [4:0] cur_q;
  logic [4:0] cur_d;

  // Shadow of the device pointer so that each returned byte can be tied to its address.
  always_comb cur_d = xfer_start ? ptr : cur_q + 5'h01;
  always_ff @(posedge clk_sys) begin
    if (srst) cur_q <= 5'h00;
    else if (xfer_start | wr_en | rd_en) cur_q <= cur_d;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_second_byte;
    ##2 rd_en ##2 stop;
  endsequence

  chk_status_pad_zero: assert property (rd_en && cur_q == 5'h00 |=> rd_byte[6:3] == 4'h0)
    else $error("status pad bits not zero");
  chk_result_low_zero: assert property (rd_en && (cur_q == 5'h02 || cur_q == 5'h04)
    |=> rd_byte[3:0] == 4'h0) else $error("result low nibble not zero");
  chk_setup_pad_zero: assert property (rd_en && (cur_q == 5'h0b || cur_q == 5'h0e)
    |=> rd_byte[4:0] == 5'h00) else $error("setup pad bits not zero");
  chk_unmapped_zero: assert property (rd_en && cur_q > 5'h0e |=> rd_byte == 8'h00)
    else $error("unmapped read not zero");
  chk_rdbyte_hold: assert property (!rd_en |=> $stable(rd_byte))
    else $error("read byte changed without a read");
  chk_start_alone: assert property (xfer_start |-> !wr_en && !rd_en && !stop)
    else $error("start overlaps a byte or stop");
  chk_start_then_byte: assert property (xfer_start |=> wr_en || rd_en)
    else $error("no byte after start");
  chk_result_pair: assert property (rd_en && (cur_q == 5'h01 || cur_q == 5'h03)
    |-> s_second_byte) else $error("result not read as one pair");
  chk_stop_bound: assert property (xfer_start |-> ##[2:6] stop)
    else $error("transfer not closed by stop");
  chk_write_alone: assert property (wr_en |-> !rd_en && !stop)
    else $error("write overlaps read or stop");
  chk_wrbyte_hold: assert property ($changed(wr_byte) |-> wr_en)
    else $error("write byte changed without a write");
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking testbench of the converter register block driven by its host controller.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [15:0] G1 = 16'h0400;
  localparam logic [15:0] G2 = 16'h0200;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic [1:0]  addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        conv_done = 1'b0;
  logic        conv_chan = 1'b0;
  logic        conv_offset_cal = 1'b0;
  logic [15:0] conv_raw = 16'h0000;
  logic        supply_low = 1'b0;
  logic        power_down_mode = 1'b0;
  logic [1:0]  span_sel_ch1;
  logic [1:0]  span_sel_ch2;
  logic        diff_input_select_ch1;
  logic        diff_input_select_ch2;
  int          n_errors = 0;
  int          n_tests = 0;

  always #12.5 clk_sys = ~clk_sys;

  cdc_link i_cdc_link ();
  cdc_device #(.SCALE_CH1_INIT(G1), .SCALE_CH2_INIT(G2)) i_cdc_device (
    .clk_sys, .srst, .ce, .link(i_cdc_link), .conv_done, .conv_chan, .conv_offset_cal,
    .conv_raw, .supply_low, .power_down_mode, .span_sel_ch1, .diff_input_select_ch1,
    .span_sel_ch2, .diff_input_select_ch2);
  cdc_host i_cdc_host (.clk_sys, .srst, .ce, .addr, .wdata, .wr, .rd, .rdata,
    .link(i_cdc_link));
  cdc_link_checker i_cdc_link_checker (.clk_sys, .srst, .xfer_start(i_cdc_link.xfer_start),
    .ptr(i_cdc_link.ptr), .wr_en(i_cdc_link.wr_en), .wr_byte(i_cdc_link.wr_byte),
    .rd_en(i_cdc_link.rd_en), .rd_byte(i_cdc_link.rd_byte), .stop(i_cdc_link.stop));

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One software port cycle; read data is sampled after the edge that takes the read.
  task automatic sw(input logic [1:0] a, input logic [15:0] d, input logic w);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask

  task automatic go(input logic [4:0] p, input logic rdq, input logic two, input logic [15:0] v);
    if (!rdq) sw(cdc_pkg::HOST_DATA, v, 1'b1);
    sw(cdc_pkg::HOST_CMD, {6'h00, two, rdq, 3'h0, p}, 1'b1);
  endtask

  task automatic fin(output logic [15:0] v);
    logic [15:0] s;
    s = 16'h0001;
    for (int i = 0; i < 20 && s[0] !== 1'b0; i++) begin
      sw(cdc_pkg::HOST_STAT, 16'h0000, 1'b0);
      s = rdata;
    end
    if (s[0] !== 1'b0) chk(s, 16'h0000);
    sw(cdc_pkg::HOST_DATA, 16'h0000, 1'b0);
    v = rdata;
  endtask

  task automatic rr(input logic [4:0] p, input logic two, input logic [15:0] e);
    logic [15:0] v;
    go(p, 1'b1, two, 16'h0000);
    fin(v);
    chk(two ? v : {8'h00, v[7:0]}, e);
  endtask

  task automatic ww(input logic [4:0] p, input logic two, input logic [15:0] v);
    logic [15:0] d;
    go(p, 1'b0, two, v);
    fin(d);
  endtask

  task automatic conv(input logic ch, input logic cal, input logic [15:0] raw);
    @(posedge clk_sys);
    conv_done <= 1'b1;
    conv_chan <= ch;
    conv_offset_cal <= cal;
    conv_raw <= raw;
    @(posedge clk_sys);
    conv_done <= 1'b0;
  endtask

  function automatic logic [15:0] res(input logic [15:0] raw, input logic [15:0] zero,
                                      input logic [15:0] gain, input logic diff);
    longint t;
    t = longint'(raw) - longint'(zero) + (diff ? 64'sh8000 : 64'sh3000);
    t = (t * (65536 + longint'(gain))) >>> 16;
    if (diff) t = t + 32768;
    if (t < 0) t = 0;
    if (t > 65520) t = 65520;
    return 16'(t) & 16'hfff0;
  endfunction

  task automatic t_reset;
    rr(cdc_pkg::ADDR_STATUS, 1'b0, 16'h0003);
    rr(cdc_pkg::ADDR_RES1_HI, 1'b1, 16'h0000);
    rr(cdc_pkg::ADDR_RES2_HI, 1'b1, 16'h0000);
    rr(cdc_pkg::ADDR_ZERO1_HI, 1'b1, 16'h8000);
    rr(cdc_pkg::ADDR_ZERO2_HI, 1'b1, 16'h8000);
    rr(cdc_pkg::ADDR_SCALE2_HI, 1'b1, G2);
    rr(5'h0f, 1'b1, 16'h0000);
    rr(5'h1f, 1'b1, 16'h0003);
    sw(2'h3, 16'h0000, 1'b0);
    chk(rdata, 16'h0000);
  endtask

  task automatic t_sleep;
    @(posedge clk_sys);
    supply_low <= 1'b1;
    rr(cdc_pkg::ADDR_STATUS, 1'b0, 16'h0083);
    @(posedge clk_sys);
    supply_low <= 1'b0;
    power_down_mode <= 1'b1;
    rr(cdc_pkg::ADDR_STATUS, 1'b0, 16'h0083);
    @(posedge clk_sys);
    power_down_mode <= 1'b0;
    rr(cdc_pkg::ADDR_STATUS, 1'b0, 16'h0003);
  endtask

  task automatic t_diff;
    ww(cdc_pkg::ADDR_SETUP1, 1'b0, 16'h00e0);
    rr(cdc_pkg::ADDR_SETUP1, 1'b0, 16'h00e0);
    chk({15'h0000, diff_input_select_ch1}, 16'h0001);
    chk({14'h0000, span_sel_ch1}, 16'h0003);
    conv(1'b0, 1'b0, 16'h1234);
    rr(cdc_pkg::ADDR_STATUS, 1'b0, 16'h0002);
    rr(cdc_pkg::ADDR_RES1_HI, 1'b1, res(16'h1234, 16'h8000, G1, 1'b1));
    rr(cdc_pkg::ADDR_STATUS, 1'b0, 16'h0003);
    conv(1'b0, 1'b0, 16'hffff);
    rr(cdc_pkg::ADDR_RES1_HI, 1'b1, 16'hfff0);
  endtask

  task automatic t_se;
    for (int c = 0; c < 4; c++) begin
      ww(cdc_pkg::ADDR_SETUP2, 1'b0, {8'h00, 2'(c), 6'h00});
      chk({14'h0000, span_sel_ch2}, 16'(c));
    end
    chk({15'h0000, diff_input_select_ch2}, 16'h0000);
    ww(cdc_pkg::ADDR_ZERO2_HI, 1'b1, 16'h3100);
    rr(cdc_pkg::ADDR_ZERO2_HI, 1'b1, 16'h3100);
    conv(1'b1, 1'b0, 16'h5000);
    rr(cdc_pkg::ADDR_STATUS, 1'b0, 16'h0005);
    rr(cdc_pkg::ADDR_RES2_HI, 1'b1, res(16'h5000, 16'h3100, G2, 1'b0));
    conv(1'b1, 1'b0, 16'h0000);
    rr(cdc_pkg::ADDR_RES2_HI, 1'b1, 16'h0000);
    rr(cdc_pkg::ADDR_ZERO1_HI, 1'b1, 16'h8000);
  endtask

  // A conversion lands while the result read is open; it must be lost.
  task automatic t_block;
    logic [15:0] v;
    conv(1'b1, 1'b0, 16'h4000);
    go(cdc_pkg::ADDR_RES2_HI, 1'b1, 1'b1, 16'h0000);
    @(posedge clk_sys);
    conv(1'b1, 1'b0, 16'h6000);
    fin(v);
    chk(v, res(16'h4000, 16'h3100, G2, 1'b0));
    rr(cdc_pkg::ADDR_STATUS, 1'b0, 16'h0007);
    rr(cdc_pkg::ADDR_RES2_HI, 1'b1, res(16'h4000, 16'h3100, G2, 1'b0));
    conv(1'b1, 1'b0, 16'h6000);
    rr(cdc_pkg::ADDR_RES2_HI, 1'b1, res(16'h6000, 16'h3100, G2, 1'b0));
  endtask

  task automatic t_cal;
    conv(1'b0, 1'b1, 16'h0123);
    rr(cdc_pkg::ADDR_ZERO1_HI, 1'b1, 16'h8123);
    rr(cdc_pkg::ADDR_STATUS, 1'b0, 16'h0007);
  endtask

  // A conversion offered while the clock enable is low must leave flags and data alone.
  task automatic t_freeze;
    @(posedge clk_sys);
    ce <= 1'b0;
    conv(1'b0, 1'b0, 16'h4000);
    @(posedge clk_sys);
    ce <= 1'b1;
    rr(cdc_pkg::ADDR_STATUS, 1'b0, 16'h0007);
    rr(cdc_pkg::ADDR_RES1_HI, 1'b1, 16'hfff0);
  endtask

  initial begin
    #(25 * 20000);
    n_errors++;
    end_sim;
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_sleep;
    t_diff;
    t_se;
    t_block;
    t_cal;
    t_freeze;
    end_sim;
  end
endmodule
`default_nettype wire
